// ==== core/imac_unit.v ====
/*
 Integer multiply, not-and, negate and negative multiply-accumulate
 datapath with its overflow flags, condition field zero and an
 AXI4-Lite register window with one level interrupt.
 Assumes decoded operands arrive synchronous to core_clk_i, one
 operation per op_valid_i pulse, and that the register file writes
 res_o to the destination when res_valid_o is high.
*/
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "imac_defs.vh"

// What this block does
// - Unsigned high-halfword multiply: upper halves of both sources.
// - Signed high-word multiply returns the top word of the product.
// - Unsigned high-word multiply returns the top word of the product.
// - Signed low-halfword multiply: lower halves of both sources.
// - Unsigned low-halfword multiply: lower halves of both sources.
// - Immediate multiply: sign-extended constant times source, low word.
// - Low-word multiply returns the low word of the signed product.
// - With overflow-enable, a low-word product not fitting sets both flags.
// - Not-and writes the complement of the AND of both sources.
// - Negate writes the two's complement and may update both flags.
// - Modulo negative accumulate adds the negated product, keeps 32 bits.
// - Accumulate pairings are cross, high and low halfwords.
// - Saturating accumulate clamps to the nearest signed limit.
// - With overflow-enable, accumulate updates both flags.
// - With the record bit, condition field zero follows the result, except for immediate multiply.
// - The low product word is taken the same for signed and unsigned.
module imac_unit #(
    parameter DATA_W = 32
) (
    input wire core_clk_i,
    input wire reset_i,
    input wire op_valid_i,
    input wire [3:0] op_i,
    input wire oe_i,
    input wire record_bit_i,
    input wire [DATA_W-1:0] src_a_reg_i,
    input wire [DATA_W-1:0] src_b_reg_i,
    input wire [DATA_W-1:0] dest_reg_i,
    input wire [15:0] const_field_i,
    output reg res_valid_o,
    output reg [DATA_W-1:0] res_o,
    output wire arith_excess_flag_o,
    output wire sticky_flag_o,
    output wire [3:0] cond_field_zero_o,
    output wire irq_o,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

// ----------------------------------------
// Operand slices
// ----------------------------------------
wire [15:0] a_hi = src_a_reg_i[31:16];
wire [15:0] a_lo = src_a_reg_i[15:0];
wire [15:0] b_hi = src_b_reg_i[31:16];
wire [15:0] b_lo = src_b_reg_i[15:0];

// ----------------------------------------
// Multipliers
// ----------------------------------------
// signed full product
wire signed [63:0] prod_ss =
    $signed(src_a_reg_i) * $signed(src_b_reg_i);
wire [63:0] prod_uu = src_a_reg_i * src_b_reg_i;
wire [31:0] prod_hhu = a_hi * b_hi;
wire [31:0] prod_llu = a_lo * b_lo;
wire signed [31:0] prod_hhs = $signed(a_hi) * $signed(b_hi);
wire signed [31:0] prod_lls = $signed(a_lo) * $signed(b_lo);
wire signed [31:0] prod_cxs = $signed(a_lo) * $signed(b_hi);
wire signed [47:0] prod_imm =
    $signed(src_a_reg_i) * $signed(const_field_i);

// product fits only if top word mirrors bit 31
wire mul_ovf = prod_ss[63:32] != {32{prod_ss[31]}};

// ----------------------------------------
// Negative multiply-accumulate
// ----------------------------------------
reg [31:0] mac_prod;
always @* begin
    case (op_i)
        `IMAC_OP_NMAC_CM, `IMAC_OP_NMAC_CS: begin
            mac_prod = prod_cxs;
        end
        `IMAC_OP_NMAC_HM, `IMAC_OP_NMAC_HS: begin
            mac_prod = prod_hhs;
        end
        default: begin
            mac_prod = prod_lls;
        end
    endcase
end

wire [31:0] nprod = ~mac_prod + 32'h0000_0001;
wire [32:0] mac_sum = {1'b0, nprod} + {1'b0, dest_reg_i};
wire mac_ovf = (nprod[31] == dest_reg_i[31]) &&
    (dest_reg_i[31] != mac_sum[31]);
wire [31:0] mac_sat = {dest_reg_i[31], {31{~dest_reg_i[31]}}};

// only the most negative value overflows
wire neg_ovf = src_a_reg_i == `IMAC_SMIN;

wire op_sat = (op_i == `IMAC_OP_NMAC_CS) ||
    (op_i == `IMAC_OP_NMAC_HS) || (op_i == `IMAC_OP_NMAC_LS);

// ----------------------------------------
// Result and overflow select
// ----------------------------------------
reg [31:0] res_d;
reg ovf_d;
reg sat_evt;
always @* begin
    res_d = `IMAC_RST_WORD;
    ovf_d = 1'b0;
    sat_evt = 1'b0;
    case (op_i)
        `IMAC_OP_MULHHWU: begin
            res_d = prod_hhu;
        end
        `IMAC_OP_MULHW: begin
            res_d = prod_ss[63:32];
        end
        `IMAC_OP_MULHWU: begin
            res_d = prod_uu[63:32];
        end
        `IMAC_OP_MULLHW: begin
            res_d = prod_lls;
        end
        `IMAC_OP_MULLHWU: begin
            res_d = prod_llu;
        end
        `IMAC_OP_MULLI: begin
            res_d = prod_imm[31:0];
        end
        `IMAC_OP_MULLW: begin
            res_d = prod_ss[31:0];
            ovf_d = mul_ovf;
        end
        `IMAC_OP_NAND: begin
            res_d = ~(src_a_reg_i & src_b_reg_i);
        end
        `IMAC_OP_NEG: begin
            res_d = ~src_a_reg_i + 32'h0000_0001;
            ovf_d = neg_ovf;
        end
        `IMAC_OP_NMAC_CM, `IMAC_OP_NMAC_HM,
        `IMAC_OP_NMAC_LM: begin
            res_d = mac_sum[31:0];
            ovf_d = mac_ovf;
        end
        `IMAC_OP_NMAC_CS, `IMAC_OP_NMAC_HS,
        `IMAC_OP_NMAC_LS: begin
            res_d = mac_ovf ? mac_sat : mac_sum[31:0];
            ovf_d = mac_ovf;
            sat_evt = mac_ovf;
        end
        default: begin
            res_d = `IMAC_RST_WORD;
        end
    endcase
end

// Only these operations carry an overflow-enable form
wire oe_legal = (op_i == `IMAC_OP_MULLW) || (op_i == `IMAC_OP_NEG) ||
    ((op_i >= `IMAC_OP_NMAC_CM) && (op_i <= `IMAC_OP_NMAC_LS));
wire flag_upd = op_valid_i && oe_i && oe_legal;
// condition field written only with record bit
wire cr_upd = op_valid_i && record_bit_i && (op_i != `IMAC_OP_MULLI);

// ----------------------------------------
// Register bus state
// ----------------------------------------
reg [1:0] fxe_q;
reg [3:0] cr_q;
reg [1:0] ist_q;
reg [1:0] imsk_q;
reg [4:0] awaddr_q;
reg aw_full_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg w_full_q;

assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
assign s_axi_wready = !w_full_q && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

// Either channel may arrive first; commit when both are held
wire wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
wire wr_map = (awaddr_q == `IMAC_ADR_FXE) ||
    (awaddr_q == `IMAC_ADR_IST) || (awaddr_q == `IMAC_ADR_IMSK);
wire wr_lane0 = wr_fire && wr_map && wstrb_q[0];
wire wr_fxe = wr_lane0 && (awaddr_q == `IMAC_ADR_FXE);
wire wr_ist = wr_lane0 && (awaddr_q == `IMAC_ADR_IST);
wire wr_imsk = wr_lane0 && (awaddr_q == `IMAC_ADR_IMSK);

always @(posedge core_clk_i) begin
    if (reset_i) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        awaddr_q <= 5'h00;
        wdata_q <= `IMAC_RST_WORD;
        wstrb_q <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `IMAC_RESP_OK;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? `IMAC_RESP_OK : `IMAC_RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------
// Flags and condition field zero
// ----------------------------------------
wire so_next = flag_upd ? (fxe_q[`IMAC_FXE_SO] | ovf_d) :
    fxe_q[`IMAC_FXE_SO];

always @(posedge core_clk_i) begin
    if (reset_i) begin
        fxe_q <= `IMAC_RST_FLAGS;
        cr_q <= `IMAC_RST_CR;
    end else begin
        // Hardware update wins over a same-cycle software write
        if (flag_upd) begin
            fxe_q[`IMAC_FXE_AEF] <= ovf_d;
            fxe_q[`IMAC_FXE_SO] <= so_next;
        end else if (wr_fxe) begin
            fxe_q[`IMAC_FXE_AEF] <= wdata_q[`IMAC_FXE_AEF];
            fxe_q[`IMAC_FXE_SO] <= wdata_q[`IMAC_FXE_SO];
        end
        if (cr_upd) begin
            cr_q[`IMAC_CR_LT] <= res_d[31];
            cr_q[`IMAC_CR_GT] <= !res_d[31] && (res_d != 32'h0);
            cr_q[`IMAC_CR_EQ] <= res_d == 32'h0;
            cr_q[`IMAC_CR_SO] <= so_next;
        end
    end
end

assign arith_excess_flag_o = fxe_q[`IMAC_FXE_AEF];
assign sticky_flag_o = fxe_q[`IMAC_FXE_SO];
assign cond_field_zero_o = cr_q;

// ----------------------------------------
// Result register
// ----------------------------------------
always @(posedge core_clk_i) begin
    if (reset_i) begin
        res_valid_o <= 1'b0;
        res_o <= `IMAC_RST_WORD;
    end else begin
        res_valid_o <= op_valid_i;
        if (op_valid_i) begin
            res_o <= res_d;
        end
    end
end

// ----------------------------------------
// Interrupt status and mask
// ----------------------------------------
wire [1:0] evt = {op_valid_i && op_sat && sat_evt,
    flag_upd && ovf_d};

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ist
        always @(posedge core_clk_i) begin
            if (reset_i) begin
                ist_q[gi] <= 1'b0;
            end else if (evt[gi]) begin
                // Set beats write-one-to-clear
                ist_q[gi] <= 1'b1;
            end else if (wr_ist && wdata_q[gi]) begin
                ist_q[gi] <= 1'b0;
            end
        end
    end
endgenerate

always @(posedge core_clk_i) begin
    if (reset_i) begin
        imsk_q <= `IMAC_RST_FLAGS;
    end else if (wr_imsk) begin
        imsk_q <= wdata_q[1:0];
    end
end

assign irq_o = |(ist_q & imsk_q);

// ----------------------------------------
// Read channel
// ----------------------------------------
reg [31:0] rd_word;
reg rd_map;
always @* begin
    rd_word = `IMAC_RST_WORD;
    rd_map = 1'b1;
    case (s_axi_araddr)
        `IMAC_ADR_FXE: begin
            rd_word = {30'h0, fxe_q};
        end
        `IMAC_ADR_CFZ: begin
            rd_word = {28'h0, cr_q};
        end
        `IMAC_ADR_IST: begin
            rd_word = {30'h0, ist_q};
        end
        `IMAC_ADR_IMSK: begin
            rd_word = {30'h0, imsk_q};
        end
        `IMAC_ADR_RES: begin
            rd_word = res_o;
        end
        default: begin
            rd_map = 1'b0;
        end
    endcase
end

always @(posedge core_clk_i) begin
    if (reset_i) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= `IMAC_RST_WORD;
        s_axi_rresp <= `IMAC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_map ? `IMAC_RESP_OK : `IMAC_RESP_ERR;
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule

// ==== core/imac_defs.vh ====
/*
 Constants of the multiply and accumulate unit: operation codes,
 register offsets, field positions and reset values.
 Assumes inclusion by core/imac_unit.v only.
*/
`ifndef IMAC_DEFS_VH
`define IMAC_DEFS_VH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define IMAC_OP_MULHHWU 4'h0
`define IMAC_OP_MULHW 4'h1
`define IMAC_OP_MULHWU 4'h2
`define IMAC_OP_MULLHW 4'h3
`define IMAC_OP_MULLHWU 4'h4
`define IMAC_OP_MULLI 4'h5
`define IMAC_OP_MULLW 4'h6
`define IMAC_OP_NAND 4'h7
`define IMAC_OP_NEG 4'h8
`define IMAC_OP_NMAC_CM 4'h9
`define IMAC_OP_NMAC_HM 4'ha
`define IMAC_OP_NMAC_LM 4'hb
`define IMAC_OP_NMAC_CS 4'hc
`define IMAC_OP_NMAC_HS 4'hd
`define IMAC_OP_NMAC_LS 4'he

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define IMAC_ADR_FXE 5'h00
`define IMAC_ADR_CFZ 5'h04
`define IMAC_ADR_IST 5'h08
`define IMAC_ADR_IMSK 5'h0c
`define IMAC_ADR_RES 5'h10

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define IMAC_FXE_SO 1
`define IMAC_FXE_AEF 0
`define IMAC_IST_OVF 0
`define IMAC_IST_SAT 1
`define IMAC_CR_LT 3
`define IMAC_CR_GT 2
`define IMAC_CR_EQ 1
`define IMAC_CR_SO 0
`define IMAC_RST_FLAGS 2'h0
`define IMAC_RST_CR 4'h0
`define IMAC_RST_WORD 32'h0000_0000
`define IMAC_SMIN 32'h8000_0000
`define IMAC_RESP_OK 2'h0
`define IMAC_RESP_ERR 2'h2

`endif

// ==== verification/imac_unit_sva.sv ====
/* Port assertions for the multiply unit.
   Assumes a bind onto imac_unit; one clock, synchronous reset. */
`timescale 1ns/1ps
module imac_unit_chk (
    input wire core_clk_i,
    input wire reset_i,
    input wire op_valid_i,
    input wire [3:0] op_i,
    input wire oe_i,
    input wire record_bit_i,
    input wire [31:0] src_a_reg_i,
    input wire [31:0] src_b_reg_i,
    input wire res_valid_o,
    input wire [31:0] res_o,
    input wire arith_excess_flag_o,
    input wire sticky_flag_o,
    input wire [3:0] cond_field_zero_o,
    input wire s_axi_wvalid
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    property p_answer; op_valid_i ##1 !op_valid_i |->
        res_valid_o ##1 !res_valid_o; endproperty
    a_answer: assert property (p_answer) else $error("bad pulse");
    property p_hhwu; op_valid_i && op_i == 4'h0 |=> res_o ==
        $past(src_a_reg_i[31:16]) * $past(src_b_reg_i[31:16]); endproperty
    a_hhwu: assert property (p_hhwu) else $error("bad product");
    property p_nand; op_valid_i && op_i == 4'h7 |=>
        res_o == ~($past(src_a_reg_i) & $past(src_b_reg_i)); endproperty
    a_nand: assert property (p_nand) else $error("bad nand");
    property p_neg; op_valid_i && op_i == 4'h8 |=>
        res_o == ~$past(src_a_reg_i) + 32'h1; endproperty
    a_neg: assert property (p_neg) else $error("bad negate");
    property p_neg_ovf; op_valid_i && op_i == 4'h8 && oe_i &&
        src_a_reg_i == 32'h8000_0000 |=> arith_excess_flag_o && sticky_flag_o;
    endproperty
    a_neg_ovf: assert property (p_neg_ovf) else $error("no overflow");
    property p_flag_hold; op_valid_i && !oe_i && !s_axi_wvalid &&
        !$past(s_axi_wvalid) |=> $stable(arith_excess_flag_o) &&
        $stable(sticky_flag_o); endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("no hold");
    property p_cr_hold; op_valid_i && !record_bit_i |=>
        $stable(cond_field_zero_o); endproperty
    a_cr_hold: assert property (p_cr_hold) else $error("field moved");
    property p_cr_set; op_valid_i && record_bit_i && op_i != 4'h5 |=>
        cond_field_zero_o == {res_o[31], !res_o[31] && |res_o, ~|res_o,
        sticky_flag_o}; endproperty
    a_cr_set: assert property (p_cr_set) else $error("bad field");
endmodule

bind imac_unit imac_unit_chk chk_u (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .op_valid_i(op_valid_i), .op_i(op_i), .oe_i(oe_i),
    .record_bit_i(record_bit_i), .src_a_reg_i(src_a_reg_i),
    .src_b_reg_i(src_b_reg_i), .res_valid_o(res_valid_o), .res_o(res_o),
    .arith_excess_flag_o(arith_excess_flag_o),
    .sticky_flag_o(sticky_flag_o), .cond_field_zero_o(cond_field_zero_o),
    .s_axi_wvalid(s_axi_wvalid));

// ==== verification/imac_rf_model.sv ====
/* Register file stand-in holding the accumulating destination.
   Assumes every result pulse of the unit writes that register. */
`timescale 1ns/1ps
module imac_rf_model (
    input wire core_clk_i,
    input wire reset_i,
    input wire wb_valid_i,
    input wire [31:0] wb_data_i,
    output reg [31:0] dest_o
);
    // Write-back lands one edge after the result pulse
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            dest_o <= 32'h0;
        end else if (wb_valid_i) begin
            dest_o <= wb_data_i;
        end
    end
endmodule

// ==== verification/imac_unit_tb.sv ====
/* Self-checking bench for imac_unit against an integer model.
   Assumes the unit, its checker and the register file model. */
`timescale 1ns/1ps
module imac_unit_tb;
    reg clk, rst, opv, oe, rec, awv, wv, br, arv, rr;
    reg [3:0] op, ws;
    reg [31:0] a, b, wd, t, acc_m, msk_m;
    reg [15:0] k;
    reg [4:0] aw, ar;
    reg [1:0] ist_m, rsp;
    reg [3:0] cr_m;
    reg aef_m, so_m;
    wire [31:0] dst, res, rd;
    wire rv, aef, so, irq, awr, wr, bv, arr, rdv;
    wire [3:0] cr;
    wire [1:0] bresp, rresp;
    integer checks = 0, failures = 0, seed = 88, i;
    imac_unit dut_u (.core_clk_i(clk), .reset_i(rst), .op_valid_i(opv),
        .op_i(op), .oe_i(oe), .record_bit_i(rec), .src_a_reg_i(a),
        .src_b_reg_i(b), .dest_reg_i(dst), .const_field_i(k),
        .res_valid_o(rv), .res_o(res), .arith_excess_flag_o(aef),
        .sticky_flag_o(so), .cond_field_zero_o(cr), .irq_o(irq),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rdv), .s_axi_rready(rr));
    imac_rf_model rf_u (.core_clk_i(clk), .reset_i(rst), .wb_valid_i(rv),
        .wb_data_i(res), .dest_o(dst));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic [33:0] ref_op(input [3:0] o, input [31:0] x, y, d,
            input [15:0] c);
        longint p;
        reg [31:0] r, n;
        reg [15:0] h, g;
        reg v, s;
        {v, s} = 0;
        h = (o == 4'ha || o == 4'hd) ? x[31:16] : x[15:0];
        g = (o == 4'hb || o == 4'he) ? y[15:0] : y[31:16];
        p = $signed(x) * $signed(y);
        case (o)
            4'h0: r = x[31:16] * y[31:16];
            4'h1: r = p[63:32];
            4'h2: begin
                p = {32'h0, x} * {32'h0, y};
                r = p[63:32];
            end
            4'h3: r = $signed(x[15:0]) * $signed(y[15:0]);
            4'h4: r = x[15:0] * y[15:0];
            4'h5: r = x * {{16{c[15]}}, c};
            4'h6: begin
                r = p[31:0];
                v = p != $signed(r);
            end
            4'h7: r = ~(x & y);
            4'h8: begin
                r = -x;
                v = x == 32'h8000_0000;
            end
            default: begin
                n = -($signed(h) * $signed(g));
                r = n + d;
                v = n[31] == d[31] && r[31] != d[31];
                s = v && o > 4'hb;
                if (s) r = d[31] ? 32'h8000_0000 : 32'h7fff_ffff;
            end
        endcase
        ref_op = {s, v, r};
    endfunction
    task chk_w(input [31:0] g, e);
        checks = checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task run_op(input [3:0] o, input [31:0] x, y, input [15:0] c,
            input e, r);
        reg [33:0] m;
        @(posedge clk);
        {op, a, b, k, oe, rec, opv} <= {o, x, y, c, e, r, 1'b1};
        m = ref_op(o, x, y, acc_m, c);
        acc_m = m[31:0];
        if (e && (o == 4'h6 || o > 4'h7)) begin
            aef_m = m[32];
            so_m = so_m | m[32];
            ist_m[0] = ist_m[0] | m[32];
        end
        ist_m[1] = ist_m[1] | m[33];
        if (r && o != 4'h5) cr_m = {m[31], !m[31] && |acc_m, ~|acc_m, so_m};
        @(posedge clk);
        opv <= 1'b0;
        #1;
        chk_w(res, acc_m);
        chk_w({aef, so, cr, irq},
            {aef_m, so_m, cr_m, |(ist_m & msk_m)});
    endtask
    task axw(input [4:0] ad, input [31:0] dt, output [1:0] rp);
        reg ta, tw;
        @(posedge clk);
        {aw, wd, awv, wv, br} <= {ad, dt, 3'h7};
        {ta, tw} = 0;
        do begin
            @(posedge clk);
            ta = ta | awr;
            tw = tw | wr;
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!(ta && tw));
        do @(posedge clk); while (!bv);
        br <= 1'b0;
        rp = bresp;
    endtask
    task axr(input [4:0] ad, output [31:0] dt, output [1:0] rp);
        @(posedge clk);
        {ar, arv, rr} <= {ad, 2'h3};
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rdv);
        rr <= 1'b0;
        dt = rd;
        rp = rresp;
    endtask
    task print_verdict;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Cut a hang well past the expected run of some 700 cycles
    initial begin
        #100000;
        failures = failures + 1;
        print_verdict;
    end
    initial begin
        rst = 1'b1;
        {opv, op, oe, rec, a, b, k, aw, ar, wd, awv, wv, br, arv, rr} = 0;
        {acc_m, msk_m, ist_m, aef_m, so_m, cr_m} = 0;
        ws = 4'hf;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        axw(5'h0c, 32'h3, rsp);
        msk_m = 3;
        run_op(4'h8, 32'h8000_0000, 0, 0, 1, 1);
        axr(5'h08, t, rsp);
        chk_w(t, ist_m);
        axw(5'h08, 32'h1, rsp);
        ist_m[0] = 1'b0;
        axr(5'h00, t, rsp);
        chk_w(t, {so_m, aef_m});
        axw(5'h00, 32'h0, rsp);
        {aef_m, so_m} = 0;
        run_op(4'h8, 32'h8000_0001, 0, 0, 0, 1);
        run_op(4'hd, 32'hffff_0000, 32'h0001_0000, 0, 1, 1);
        run_op(4'ha, 32'hffff_0000, 32'h0001_0000, 0, 1, 0);
        run_op(4'hc, 32'h0000_0001, 32'h0001_0000, 0, 0, 1);
        run_op(4'h6, 32'h0001_0000, 32'h0001_0000, 0, 1, 1);
        run_op(4'h5, 32'h3, 0, 16'hfffe, 1, 1);
        axr(5'h04, t, rsp);
        chk_w(t, cr_m);
        axr(5'h10, t, rsp);
        chk_w(t, acc_m);
        axr(5'h14, t, rsp);
        chk_w(rsp, 2);
        axw(5'h18, 32'h3, rsp);
        chk_w(rsp, 2);
        axw(5'h08, 32'h3, rsp);
        ist_m = 0;
        // Lane 0 strobe low: the mask must keep its value
        ws <= 4'h0;
        axw(5'h0c, 32'h0, rsp);
        ws <= 4'hf;
        axr(5'h0c, t, rsp);
        chk_w(t, msk_m);
        for (i = 0; i < 300; i = i + 1) begin
            t = $random(seed);
            run_op(t[3:0] % 4'hf, $random(seed), $random(seed), t[31:16],
                t[4], t[5]);
        end
        // Mid-run reset returns every output to idle
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        {acc_m, msk_m, ist_m, aef_m, so_m, cr_m} = 0;
        #1;
        chk_w(res, 0);
        chk_w({rv, aef, so, cr, irq, bv, rdv, awr, wr, arr}, 32'h7);
        run_op(4'h0, 32'h0003_1234, 32'h0005_ffff, 0, 0, 1);
        print_verdict;
    end
endmodule
